// File: rtl/sswio_debounce.sv
module sswio_debounce
  import sswio_pkg::*;
#(
  parameter int unsigned DEB_CYC = DEBOUNCE_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin,
  input  wire logic active_low,
  output logic      level
);
  import sswio_pkg::*;

  logic [2:0]  sync_q;
  logic [31:0] cnt_q;
  logic        stable_q;
  wire         agreed  = (sync_q[1] == sync_q[2]);
  wire         differs = agreed && (sync_q[2] != stable_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_q   <= 3'h0;
      cnt_q    <= 32'h0;
      stable_q <= 1'b0;
    end else begin
      sync_q <= {sync_q[1:0], pin};
      if (!differs) begin
        cnt_q <= 32'h0;
      end else if (cnt_q >= DEB_CYC - 1) begin
        cnt_q    <= 32'h0;
        stable_q <= sync_q[2];
      end else begin
        cnt_q <= cnt_q + 32'h1;
      end
    end
  end

  assign level = stable_q ^ active_low;

endmodule : sswio_debounce

// File: rtl/sswio_pkg.sv
package sswio_pkg;

  // ----------------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ          = 125000000;
  localparam int unsigned DEBOUNCE_MS     = 30;
  localparam int unsigned DEBOUNCE_CYC    = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_DEF_MS    = 100;
  localparam int unsigned MS_CYC          = CLK_HZ / 1000;
  localparam int unsigned PULSE_W         = 16;

  // ----------------------------------------------------------------------
  // functions and defaults
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    SSWIO_S2_FOCUS    = 2'b00,
    SSWIO_S2_TEACH    = 2'b01,
    SSWIO_S2_INCR     = 2'b10,
    SSWIO_S2_ONESHOT  = 2'b11
  } sswio_s2_func_t;

  typedef enum logic [1:0] {
    SSWIO_OUT_READY   = 2'b00,
    SSWIO_OUT_GOOD    = 2'b01,
    SSWIO_OUT_NOREAD  = 2'b10,
    SSWIO_OUT_MATCH   = 2'b11
  } sswio_out_func_t;

  typedef struct packed {
    sswio_out_func_t func;
    logic            invert;
  } sswio_out_cfg_t;

  typedef struct packed {
    logic            good_read;
    logic            no_read;
    logic            match;
  } sswio_events_t;

  typedef struct packed {
    sswio_s2_func_t       s2_func;
    logic                 s1_active_low;
    logic                 s2_active_low;
    sswio_out_cfg_t       out1;
    sswio_out_cfg_t       out2;
    logic [PULSE_W-1:0]   pulse_ms;
    logic [23:0]          dc_table;
  } sswio_cfg_t;

  localparam logic [23:0] DC_TABLE_DEF = 24'hFAC688;
  localparam sswio_cfg_t  CFG_DEFAULT  = '{
    s2_func:       SSWIO_S2_FOCUS,
    s1_active_low: 1'b0,
    s2_active_low: 1'b0,
    out1:          '{func: SSWIO_OUT_READY, invert: 1'b0},
    out2:          '{func: SSWIO_OUT_GOOD,  invert: 1'b0},
    pulse_ms:      16'h0064,
    dc_table:      DC_TABLE_DEF
  };

endpackage : sswio_pkg

// File: rtl/sswio_pulse.sv
module sswio_pulse
  import sswio_pkg::*;
#(
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               fire,
  input  wire logic [PULSE_W-1:0] dur_ms,
  output logic                    active
);
  import sswio_pkg::*;

  logic [31:0]        tick_q;
  logic [PULSE_W-1:0] ms_q;
  logic               act_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tick_q <= 32'h0;
      ms_q   <= '0;
      act_q  <= 1'b0;
    end else if (fire && dur_ms != '0) begin
      tick_q <= 32'h0;
      ms_q   <= dur_ms;
      act_q  <= 1'b1;
    end else if (act_q) begin
      if (tick_q >= MS_CYCLES - 1) begin
        tick_q <= 32'h0;
        ms_q   <= ms_q - 1'b1;
        if (ms_q == 16'h0001) begin
          act_q <= 1'b0;
        end
      end else begin
        tick_q <= tick_q + 32'h1;
      end
    end
  end

  assign active = act_q;

endmodule : sswio_pulse

// File: rtl/sswio_top.sv
module sswio_top
  import sswio_pkg::*;
#(
  parameter int unsigned DEB_CYC   = DEBOUNCE_CYC,
  parameter int unsigned MS_CYCLES = MS_CYC
) (
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          sensor1_pin,
  input  wire logic          sensor2_pin,
  input  wire logic          reading_mode,
  input  sswio_pkg::sswio_events_t events,
  input  wire logic          cfg_wr,
  input  sswio_pkg::sswio_cfg_t cfg_in,
  input  wire logic          load_defaults,
  output sswio_pkg::sswio_cfg_t cfg_out,
  output logic               reading_active,
  output logic [2:0]         distance_config,
  output logic               teach_trigger,
  output logic               conveyor_incr,
  output logic               oneshot_trigger,
  output logic               result1,
  output logic               result2,
  output logic               result_led
);
  import sswio_pkg::*;

  // ----------------------------------------------------------------------
  // working parameter set
  // ----------------------------------------------------------------------
  sswio_cfg_t cfg_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cfg_q <= CFG_DEFAULT;
    end else if (load_defaults) begin
      cfg_q <= CFG_DEFAULT;
    end else if (cfg_wr) begin
      cfg_q <= cfg_in;
    end
  end

  assign cfg_out = cfg_q;

  // ----------------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------------
  logic s1_lvl;
  logic s2_lvl;

  sswio_debounce #(.DEB_CYC(DEB_CYC)) u_deb1 (
    .clk        (clk),
    .rst_b      (rst_b),
    .pin        (sensor1_pin),
    .active_low (cfg_q.s1_active_low),
    .level      (s1_lvl)
  );

  sswio_debounce #(.DEB_CYC(DEB_CYC)) u_deb2 (
    .clk        (clk),
    .rst_b      (rst_b),
    .pin        (sensor2_pin),
    .active_low (cfg_q.s2_active_low),
    .level      (s2_lvl)
  );

  // ----------------------------------------------------------------------
  // sensor 2 functions
  // ----------------------------------------------------------------------
  logic       s2_prev_q;
  logic [2:0] dc_q;
  logic       teach_q;
  logic       incr_q;
  logic       oneshot_q;

  wire        s2_rise  = s2_lvl && !s2_prev_q;
  wire  [2:0] dc_index = {2'b00, s2_lvl};
  wire  [2:0] dc_sel   = cfg_q.dc_table[dc_index*3 +: 3];

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s2_prev_q <= 1'b0;
      dc_q      <= 3'h0;
      teach_q   <= 1'b0;
      incr_q    <= 1'b0;
      oneshot_q <= 1'b0;
    end else begin
      s2_prev_q <= s2_lvl;
      if (cfg_q.s2_func == SSWIO_S2_FOCUS) begin
        dc_q <= dc_sel;
      end
      teach_q   <= s2_rise && cfg_q.s2_func == SSWIO_S2_TEACH;
      incr_q    <= s2_rise && cfg_q.s2_func == SSWIO_S2_INCR;
      oneshot_q <= s2_rise && cfg_q.s2_func == SSWIO_S2_ONESHOT;
    end
  end

  assign distance_config = dc_q;
  assign teach_trigger   = teach_q;
  assign conveyor_incr   = incr_q;
  assign oneshot_trigger = oneshot_q;

  // ----------------------------------------------------------------------
  // reading interval and event capture
  // ----------------------------------------------------------------------
  logic          rd_q;
  sswio_events_t seen_q;

  wire           rd_end = rd_q && !s1_lvl;
  wire           rd_on  = reading_mode && s1_lvl;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_q   <= 1'b0;
      seen_q <= '0;
    end else begin
      rd_q <= rd_on;
      if (rd_on && !rd_q) begin
        seen_q <= events;
      end else if (rd_q) begin
        seen_q <= seen_q | events;
      end
    end
  end

  assign reading_active = rd_q;

  function automatic logic ev_hit(input sswio_out_func_t f, input sswio_events_t e);
    unique case (f)
      SSWIO_OUT_GOOD:   ev_hit = e.good_read;
      SSWIO_OUT_NOREAD: ev_hit = e.no_read;
      SSWIO_OUT_MATCH:  ev_hit = e.match;
      SSWIO_OUT_READY:  ev_hit = 1'b0;
    endcase
  endfunction : ev_hit

  wire fire1 = rd_end && ev_hit(cfg_q.out1.func, seen_q);
  wire fire2 = rd_end && ev_hit(cfg_q.out2.func, seen_q);

  // ----------------------------------------------------------------------
  // result outputs
  // ----------------------------------------------------------------------
  logic p1;
  logic p2;

  sswio_pulse #(.MS_CYCLES(MS_CYCLES)) u_pulse1 (
    .clk    (clk),
    .rst_b  (rst_b),
    .fire   (fire1),
    .dur_ms (cfg_q.pulse_ms),
    .active (p1)
  );

  sswio_pulse #(.MS_CYCLES(MS_CYCLES)) u_pulse2 (
    .clk    (clk),
    .rst_b  (rst_b),
    .fire   (fire2),
    .dur_ms (cfg_q.pulse_ms),
    .active (p2)
  );

  wire act1 = (cfg_q.out1.func == SSWIO_OUT_READY) ? reading_mode : p1;
  wire act2 = (cfg_q.out2.func == SSWIO_OUT_READY) ? reading_mode : p2;

  logic r1_q;
  logic r2_q;
  logic led_q;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      r1_q  <= 1'b0;
      r2_q  <= 1'b0;
      led_q <= 1'b0;
    end else begin
      r1_q  <= act1 ^ cfg_q.out1.invert;
      r2_q  <= act2 ^ cfg_q.out2.invert;
      led_q <= reading_mode && act2;
    end
  end

  assign result1    = r1_q;
  assign result2    = r2_q;
  assign result_led = led_q;

endmodule : sswio_top

// File: testbench/sswio_sensor_model.sv
module sswio_sensor_model (
  input  wire logic clk,
  input  wire logic s1_req,
  input  wire logic s2_req,
  output logic      sensor1_pin,
  output logic      sensor2_pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // pins follow the request by non-blocking update on the sampling edge
  always @(posedge clk) begin
    sensor1_pin <= s1_req;
    sensor2_pin <= s2_req;
  end
endmodule : sswio_sensor_model

// File: testbench/sswio_top_props.sv
module sswio_top_props
  import sswio_pkg::*;
#(
  parameter int unsigned DEB_CYC   = 4,
  parameter int unsigned MS_CYCLES = 10
) (
  input  wire logic      clk,
  input  wire logic      rst_b,
  input  wire logic      sensor1_pin,
  input  wire logic      sensor2_pin,
  input  wire logic      reading_mode,
  input  sswio_pkg::sswio_events_t events,
  input  wire logic      cfg_wr,
  input  sswio_pkg::sswio_cfg_t cfg_in,
  input  wire logic      load_defaults,
  input  sswio_pkg::sswio_cfg_t cfg_out,
  input  wire logic      reading_active,
  input  wire logic [2:0] distance_config,
  input  wire logic      teach_trigger,
  input  wire logic      conveyor_incr,
  input  wire logic      oneshot_trigger,
  input  wire logic      result1,
  input  wire logic      result2,
  input  wire logic      result_led
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence s_out2_rise;
    !result2 ##1 result2;
  endsequence
  a_defaults_copy: assert property (load_defaults |=> cfg_out == CFG_DEFAULT)
    else $error("defaults not copied");
  a_cfg_write: assert property (cfg_wr && !load_defaults |=> cfg_out == $past(cfg_in))
    else $error("config write lost");
  a_idle_no_interval: assert property (!reading_mode [*2] |-> !reading_active)
    else $error("interval outside reading mode");
  a_led_dark_idle: assert property (!reading_mode [*2] |-> !result_led)
    else $error("led lit outside reading mode");
  a_led_tracks_out2: assert property ((reading_mode && !cfg_out.out2.invert) [*2] |-> result_led == result2)
    else $error("led differs from output 2");
  a_ready_static: assert property ((cfg_out.out1.func == SSWIO_OUT_READY && reading_mode && $stable(cfg_out)) [*2] |-> result1 != cfg_out.out1.invert)
    else $error("ready output not steady");
  a_pulse_at_end: assert property (s_out2_rise ##0 (cfg_out.out2.func != SSWIO_OUT_READY && !cfg_out.out2.invert) |-> $past(reading_active, 2) && !$past(reading_active))
    else $error("pulse not at interval end");
  a_side_mode_only: assert property ((teach_trigger |-> $past(cfg_out.s2_func) == SSWIO_S2_TEACH) and (oneshot_trigger |-> $past(cfg_out.s2_func) == SSWIO_S2_ONESHOT))
    else $error("trigger in wrong mode");
  a_side_one_cycle: assert property (conveyor_incr |=> !conveyor_incr)
    else $error("increment pulse too long");
  a_dist_from_table: assert property ((cfg_out.s2_func == SSWIO_S2_FOCUS && $stable(cfg_out)) [*2] |-> distance_config inside {cfg_out.dc_table[2:0], cfg_out.dc_table[5:3]})
    else $error("distance config not from table");
endmodule : sswio_top_props

bind sswio_top sswio_top_props #(.DEB_CYC(DEB_CYC), .MS_CYCLES(MS_CYCLES)) u_props (.clk, .rst_b,
  .sensor1_pin, .sensor2_pin, .reading_mode, .events, .cfg_wr, .cfg_in, .load_defaults, .cfg_out,
  .reading_active, .distance_config, .teach_trigger, .conveyor_incr, .oneshot_trigger, .result1,
  .result2, .result_led);

// File: testbench/test_sswio_top.sv
module test_sswio_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sswio_pkg::*;
  logic clk = 0, rst_b = 0, s1 = 0, s2 = 0, rd = 0, wr = 0, ld = 0;
  logic p1, p2, ra, t, ci, os, r1, r2, led;
  logic [2:0] dc;
  sswio_events_t ev = '0;
  sswio_cfg_t cin = CFG_DEFAULT, cout, c;
  int bad_count = 0, tests_run = 0, cyc = 0, n;
  always #4 clk = ~clk;
  sswio_sensor_model u_sen (.clk, .s1_req(s1), .s2_req(s2), .sensor1_pin(p1), .sensor2_pin(p2));
  sswio_top #(.DEB_CYC(4), .MS_CYCLES(10)) DUT (.clk, .rst_b, .sensor1_pin(p1),
    .sensor2_pin(p2), .reading_mode(rd), .events(ev), .cfg_wr(wr), .cfg_in(cin),
    .load_defaults(ld), .cfg_out(cout), .reading_active(ra), .distance_config(dc),
    .teach_trigger(t), .conveyor_incr(ci), .oneshot_trigger(os), .result1(r1), .result2(r2),
    .result_led(led));
  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic write_cfg(input sswio_cfg_t v);
    cin = v;
    wr = 1;
    tick(1);
    wr = 0;
    tick(2);
  endtask : write_cfg
  // one debounced reading interval with the given events, ends after the pulse rose
  task automatic interval(input sswio_events_t e);
    s1 = 1;
    tick(12);
    ev = e;
    tick(1);
    ev = '0;
    s1 = 0;
    tick(16);
  endtask : interval
  task complete_run;
    $display("tests_run=%0d bad_count=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    tick(5);
    rst_b = 1;
    tick(2);
    chk(cout, CFG_DEFAULT);
    chk(dc, 0);
    rd = 1;
    tick(3);
    chk({r1, r2, led}, 3'b100);
    s1 = 1;
    tick(2);
    s1 = 0;
    tick(12);
    chk(ra, 0);
    interval(3'b100);
    chk({r2, led}, 2'b11);
    tick(985);
    chk(r2, 1);
    tick(25);
    chk(r2, 0);
    s2 = 1;
    tick(12);
    chk(dc, 1);
    c = CFG_DEFAULT;
    c.dc_table[5:3] = 3'h6;
    c.pulse_ms = 16'h0003;
    c.out1.func = SSWIO_OUT_NOREAD;
    c.out2.invert = 1'b1;
    write_cfg(c);
    chk({dc, r2}, 4'hD);
    interval(3'b110);
    tick(4);
    chk({r1, r2, led}, 3'b101);
    tick(24);
    chk({r1, r2}, 2'b01);
    for (int m = 1; m < 4; m++) begin
      c.s2_func = sswio_s2_func_t'(m);
      write_cfg(c);
      s2 = 0;
      tick(12);
      s2 = 1;
      n = 0;
      repeat (14) begin
        tick(1);
        n += ({t, ci, os} == (3'b100 >> (m - 1)));
      end
      chk(n, 1);
    end
    chk(dc, 6);
    c.out1.func = SSWIO_OUT_MATCH;
    c.out2.invert = 1'b0;
    write_cfg(c);
    interval(3'b001);
    chk({r1, r2}, 2'b10);
    ld = 1;
    tick(1);
    ld = 0;
    tick(1);
    chk(cout, CFG_DEFAULT);
    rd = 0;
    tick(3);
    chk({r1, led}, 2'b00);
    complete_run();
  end
endmodule : test_sswio_top
